// >>> hw/mac_ipg_timing_fcs_stats.sv
// Transmit inter-packet gap timing and receive frame-check error tally.
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "mac_ipg_defs.svh"

module mac_ipg_timing_fcs_stats (
   input wire logic I_CORE_CLK,
   input wire logic I_RST,
   input wire mac_ipg_pkg::reg_req_t I_REQ,
   input wire mac_ipg_pkg::rx_status_t I_RX_STAT,
   input wire logic I_NIBBLE_TICK,
   input wire logic I_FULL_DUPLEX,
   input wire logic I_CRS,
   input wire logic I_TX_END,
   input wire logic I_TX_B2B,
   output logic [31:0] O_RDATA,
   output logic O_TX_GAP_OK
);
   import mac_ipg_pkg::*;

   // ****************************************************
   // Input synchronisers
   // ****************************************************

   // Carrier sense comes straight from the PHY pin.
   logic crs_meta_r; // First stage, read only by the second.
   logic crs_r; // Synchronised carrier sense.

   // Two flops guard against metastability on the pin.
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         crs_meta_r <= 1'b0;
         crs_r <= 1'b0;
      end else begin
         crs_meta_r <= I_CRS;
         crs_r <= crs_meta_r;
      end
   end

   // ****************************************************
   // Register decode
   // ****************************************************

   // Picks the alias kind of an address out of its bits 3:2.
   function automatic wr_kind_t alias_kind(input logic [7:0] a);
      unique case (a[3:2])
         `ALIAS_CLR_OFS: alias_kind = WR_CLR;
         `ALIAS_SET_OFS: alias_kind = WR_SET;
         `ALIAS_INV_OFS: alias_kind = WR_INV;
         default: alias_kind = WR_PLAIN;
      endcase
   endfunction

   // Applies a plain, clear, set or invert write to a field.
   function automatic logic [15:0] apply_wr(input logic [15:0] cur,
      input logic [15:0] wd, input wr_kind_t k);
      unique case (k)
         WR_CLR: apply_wr = cur & ~wd;
         WR_SET: apply_wr = cur | wd;
         WR_INV: apply_wr = cur ^ wd;
         default: apply_wr = wd;
      endcase
   endfunction

   logic [7:0] base_addr; // Address with alias bits dropped.
   wr_kind_t wkind; // Alias kind of this access.
   logic sel_tally; // Access hits the error tally.
   logic sel_b2b; // Access hits the back-to-back gap.
   logic sel_nb2b; // Access hits the non-back-to-back gap.
   logic wide_acc; // Access is 16 or 32 bits wide.

   assign base_addr = {I_REQ.addr[7:4], 4'h0};
   assign wkind = alias_kind(I_REQ.addr);
   assign sel_tally = (base_addr == `FCS_TALLY_OFS);
   assign sel_b2b = (base_addr == `B2B_GAP_OFS);
   assign sel_nb2b = (base_addr == `NB2B_GAP_OFS);
   // Only aligned half-word or whole-word lanes count as legal here.
   assign wide_acc = (I_REQ.be == 4'hf) || (I_REQ.be == 4'h3) ||
      (I_REQ.be == 4'hc);

   // ****************************************************
   // Gap configuration registers
   // ****************************************************

   logic [6:0] b2b_gap_r; // Consecutive frame gap field.
   logic [6:0] part_one_r; // Deferral window gap field.
   logic [6:0] part_two_r; // Nonconsecutive frame gap field.
   logic [15:0] b2b_wr; // Back-to-back value after a write.
   logic [15:0] nb2b_wr; // Non-back-to-back value after a write.

   assign b2b_wr = apply_wr({9'h000, b2b_gap_r}, I_REQ.wdata[15:0], wkind);
   assign nb2b_wr = apply_wr({1'b0, part_one_r, 1'b0, part_two_r},
      I_REQ.wdata[15:0], wkind);

   // Byte-wide writes to the gap registers are dropped so a gap field is never half updated.
   // A half-word write to the upper lanes only reaches unimplemented
   // bits, so the fields in the low lanes keep their value then.
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         b2b_gap_r <= `B2B_GAP_RST;
         part_one_r <= `PART_ONE_RST;
         part_two_r <= `PART_TWO_RST;
      end else if (I_REQ.wr && wide_acc && I_REQ.be[0]) begin
         if (sel_b2b) begin
            b2b_gap_r <= b2b_wr[6:0];
         end
         if (sel_nb2b) begin
            part_one_r <= nb2b_wr[14:8];
            part_two_r <= nb2b_wr[6:0];
         end
      end
   end

   // ****************************************************
   // Frame-check error tally
   // ****************************************************

   logic [15:0] tally_r; // Frame check error tally.
   logic bad_frame; // Qualifying receive frame this cycle.
   logic tally_rd_clr; // Read that clears the tally.
   logic [15:0] tally_wr; // Tally value after a software write.

   // Only receive status feeds this; transmit never touches it.
   assign bad_frame = I_RX_STAT.done && I_RX_STAT.fcs_bad &&
      (I_RX_STAT.bit_rem == 3'h0);
   assign tally_rd_clr = I_REQ.rd && sel_tally &&
      (I_REQ.be[1:0] != 2'b00);
   assign tally_wr = apply_wr(tally_r, I_REQ.wdata[15:0], wkind);

   // A bad frame in the clearing cycle starts the new count at one,
   // so the event is never lost.
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         tally_r <= 16'h0000;
      end else if (I_REQ.wr && sel_tally) begin
         tally_r <= tally_wr + {15'h0000, bad_frame};
      end else if (tally_rd_clr) begin
         tally_r <= {15'h0000, bad_frame};
      end else if (bad_frame) begin
         tally_r <= tally_r + 16'h0001;
      end
   end

   // ****************************************************
   // Read data
   // ****************************************************

   logic [31:0] rdata_nxt; // Read value of the addressed register.

   // Unmapped addresses and unused upper bits read as zero.
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (sel_tally) begin
         rdata_nxt = {16'h0000, tally_r};
      end else if (sel_b2b) begin
         rdata_nxt = {25'h0000000, b2b_gap_r};
      end else if (sel_nb2b) begin
         rdata_nxt = {17'h00000, part_one_r, 1'b0, part_two_r};
      end
   end

   // Read data stand only in the cycle after the strobe.
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_RDATA <= 32'h0000_0000;
      end else if (I_REQ.rd) begin
         O_RDATA <= rdata_nxt;
      end else begin
         O_RDATA <= 32'h0000_0000;
      end
   end

   // ****************************************************
   // Transmit gap timer
   // ****************************************************

   gap_state_t state_r; // Gap timer state.
   logic [7:0] nib_cnt_r; // Nibble times since frame end.
   logic [7:0] b2b_target; // Back-to-back gap incl. duplex add.
   logic [7:0] part_one_t; // End of the deferral window.
   logic [7:0] part_two_t; // End of the full gap.
   logic b2b_r; // Next frame follows back to back.

   assign b2b_target = {1'b0, b2b_gap_r} + (I_FULL_DUPLEX ?
      `FULL_DUPLEX_ADD : `HALF_DUPLEX_ADD);
   assign part_one_t = {1'b0, part_one_r};
   assign part_two_t = b2b_r ? b2b_target : {1'b0, part_two_r};

   // The timer restarts at each frame end; carrier in the window
   // also restarts it, which is how the transmitter defers.
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         state_r <= GAP_READY;
         nib_cnt_r <= 8'h00;
         b2b_r <= 1'b0;
      end else if (I_TX_END) begin
         state_r <= GAP_DEFER;
         nib_cnt_r <= 8'h00;
         b2b_r <= I_TX_B2B;
      end else begin
         unique case (state_r)
            GAP_IDLE: begin
               if (!crs_r) begin
                  state_r <= GAP_DEFER;
                  nib_cnt_r <= 8'h00;
               end
            end
            GAP_DEFER: begin
               if (crs_r && !b2b_r) begin
                  state_r <= GAP_IDLE;
               end else if (b2b_r || nib_cnt_r >= part_one_t) begin
                  state_r <= GAP_FINISH;
               end else if (I_NIBBLE_TICK) begin
                  nib_cnt_r <= nib_cnt_r + 8'h01;
               end
            end
            GAP_FINISH: begin
               // Carrier no longer matters once part one is past.
               if (nib_cnt_r >= part_two_t) begin
                  state_r <= GAP_READY;
               end else if (I_NIBBLE_TICK) begin
                  nib_cnt_r <= nib_cnt_r + 8'h01;
               end
            end
            GAP_READY: begin
               nib_cnt_r <= nib_cnt_r;
            end
         endcase
      end
   end

   // Gap permission is registered so the output is glitch free.
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_TX_GAP_OK <= 1'b1;
      end else begin
         O_TX_GAP_OK <= (state_r == GAP_READY) && !I_TX_END;
      end
   end

   // ****************************************************
   // Assertions
   // ****************************************************

   a_tally_count: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      bad_frame && !I_REQ.wr && !tally_rd_clr |=>
      tally_r == $past(tally_r) + 16'h0001)
      else $error("tally did not count a bad frame");
   a_tally_odd: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      I_RX_STAT.bit_rem != 3'h0 && !I_REQ.wr && !tally_rd_clr |=>
      tally_r == $past(tally_r))
      else $error("tally counted a partial-byte frame");
   a_upper_zero: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      $past(I_REQ.rd) && $past(sel_tally) |-> O_RDATA[31:16] == 16'h0000)
      else $error("tally upper half not zero");
   a_read_clear: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      tally_rd_clr && !I_REQ.wr && !bad_frame |=> tally_r == 16'h0000)
      else $error("tally not cleared by read");
   a_byte_ignored: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      I_REQ.wr && !wide_acc |=> $stable(b2b_gap_r) && $stable(part_one_r)
      && $stable(part_two_r))
      else $error("byte write changed a gap register");
   // Deferral: the timer drops to idle, then the gap stays shut.
   sequence s_defer_then_shut;
      state_r == GAP_IDLE ##1 !O_TX_GAP_OK;
   endsequence

   a_gap_add: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      state_r == GAP_FINISH && b2b_r && !I_TX_END &&
      nib_cnt_r < {1'b0, b2b_gap_r} + (I_FULL_DUPLEX ? 8'h03 : 8'h06)
      |=> state_r != GAP_READY)
      else $error("back-to-back gap ended before duplex addition");
   a_defer_crs: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      state_r == GAP_DEFER && crs_r && !b2b_r && !I_TX_END |=>
      s_defer_then_shut)
      else $error("transmit did not defer to carrier");
   a_no_early_go: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      state_r == GAP_FINISH && nib_cnt_r < part_two_t && !I_TX_END |=>
      state_r != GAP_READY)
      else $error("gap ended before its count");
   a_finish_go: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      state_r == GAP_FINISH && nib_cnt_r >= part_two_t && !I_TX_END |=>
      state_r == GAP_READY)
      else $error("carrier stopped the second gap part");
   a_tally_wrap: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      tally_r == 16'hffff && bad_frame && !I_REQ.wr && !tally_rd_clr |=>
      tally_r == 16'h0000)
      else $error("tally did not wrap");

endmodule

// >>> inc/mac_ipg_defs.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef MAC_IPG_DEFS_SVH
`define MAC_IPG_DEFS_SVH

// Word offsets chosen for this block (byte addresses).
`define FCS_TALLY_OFS 8'h00
`define B2B_GAP_OFS 8'h10
`define NB2B_GAP_OFS 8'h20
// Alias offsets relative to the base register.
`define ALIAS_CLR_OFS 2'h1
`define ALIAS_SET_OFS 2'h2
`define ALIAS_INV_OFS 2'h3

// Field positions.
`define GAP_FIELD_W 7
`define PART_TWO_LSB 0
`define PART_ONE_LSB 8
`define TALLY_W 16

// Reset values.
`define B2B_GAP_RST 7'h12
`define PART_ONE_RST 7'h0c
`define PART_TWO_RST 7'h12

// Fixed additions to the back-to-back gap in nibble times.
`define FULL_DUPLEX_ADD 8'h03
`define HALF_DUPLEX_ADD 8'h06

`endif

// >>> inc/mac_ipg_pkg.sv
// Types shared by the gap timer and error tally block.
package mac_ipg_pkg;

   // Register bus request from software.
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic [3:0] be;
      logic wr;
      logic rd;
   } reg_req_t;

   // Receive frame status reported at the end of each frame.
   typedef struct packed {
      logic done;
      logic fcs_bad;
      logic [2:0] bit_rem;
   } rx_status_t;

   // Alias kinds of a register write.
   typedef enum logic [1:0] {
      WR_PLAIN,
      WR_CLR,
      WR_SET,
      WR_INV
   } wr_kind_t;

   // Transmit gap timer states.
   typedef enum logic [1:0] {
      GAP_IDLE,
      GAP_DEFER,
      GAP_FINISH,
      GAP_READY
   } gap_state_t;

endpackage

// >>> dv/phy_model.sv
// Behavioural PHY that paces nibble times and drives carrier sense.
`timescale 1ns/1ps

module phy_model #(
   parameter int NIB_DIV = 8
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_crs_req,
   output logic o_nibble_tick,
   output logic o_crs
);
   // Divider phase; a tick marks the last cycle of each nibble time.
   int cnt_r;

   // Carrier moves only at mid-nibble, so the two-flop sync in the MAC
   // settles well clear of the next tick and counts stay unambiguous.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_r <= 0;
         o_nibble_tick <= 1'b0;
         o_crs <= 1'b0;
      end else begin
         cnt_r <= (cnt_r == NIB_DIV - 1) ? 0 : cnt_r + 1;
         o_nibble_tick <= (cnt_r == NIB_DIV - 1);
         if (cnt_r == NIB_DIV / 2 - 1) begin
            o_crs <= i_crs_req;
         end
      end
   end
endmodule

// >>> dv/tb.sv
// Self-checking bench for the gap timer and frame-check error tally.
`timescale 1ns/1ps
`include "mac_ipg_defs.svh"

module tb;
   import mac_ipg_pkg::*;
   // ****************************************
   // Signals and instances
   // ****************************************
   logic clk = 1'b0;
   logic rst = 1'b1;
   reg_req_t req = '0;
   rx_status_t rx = '0;
   logic fdx = 1'b1;
   logic tx_end = 1'b0;
   logic tx_b2b = 1'b0;
   logic crs_req = 1'b0;
   logic tick;
   logic crs;
   logic [31:0] rdata;
   logic gap_ok;
   int mismatches = 0;
   int n_compared = 0;
   int cycles = 0;

   mac_ipg_timing_fcs_stats mac_ipg_timing_fcs_stats_inst (
      .I_CORE_CLK(clk), .I_RST(rst), .I_REQ(req), .I_RX_STAT(rx),
      .I_NIBBLE_TICK(tick), .I_FULL_DUPLEX(fdx), .I_CRS(crs),
      .I_TX_END(tx_end), .I_TX_B2B(tx_b2b), .O_RDATA(rdata),
      .O_TX_GAP_OK(gap_ok));

   phy_model phy_model_inst (.i_clk(clk), .i_rst(rst), .i_crs_req(crs_req),
      .o_nibble_tick(tick), .o_crs(crs));

   // ****************************************
   // Compare, bus and traffic tasks
   // ****************************************
   task automatic chk32(input string nm, input logic [31:0] e,
                        input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_bit(input string nm, input logic e, input logic g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d,
                         input logic [3:0] be);
      @(posedge clk);
      req.addr <= a;
      req.wdata <= d;
      req.be <= be;
      req.wr <= 1'b1;
      @(posedge clk);
      req.wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so look there.
   task automatic reg_rd(input string nm, input logic [7:0] a,
                         input logic [3:0] be, input logic [31:0] e);
      @(posedge clk);
      req.addr <= a;
      req.be <= be;
      req.rd <= 1'b1;
      @(posedge clk);
      req.rd <= 1'b0;
      @(negedge clk);
      chk32(nm, e, rdata);
   endtask

   task automatic frame(input logic bad, input logic [2:0] rem);
      @(posedge clk);
      rx <= '{done: 1'b1, fcs_bad: bad, bit_rem: rem};
      @(posedge clk);
      rx.done <= 1'b0;
   endtask

   // Counts nibble ticks from the end of a frame until the gap opens.
   // With restart set, carrier seen restarts the count, as the MAC does.
   task automatic gap_run(input string nm, input logic b2b, input logic fd,
                          input int crs_at, input logic restart,
                          input int e);
      int n;
      int held;
      bit fired;
      n = 0;
      held = 0;
      fired = 0;
      @(posedge clk);
      fdx <= fd;
      @(negedge clk);
      while (tick !== 1'b1) @(negedge clk);
      @(posedge clk);
      tx_end <= 1'b1;
      tx_b2b <= b2b;
      @(posedge clk);
      tx_end <= 1'b0;
      @(negedge clk);
      chk_bit({nm, " closed"}, 1'b0, gap_ok);
      for (int c = 0; c < 2000 && gap_ok !== 1'b1; c++) begin
         if (restart && crs) n = 0;
         else if (tick) n++;
         if (n == crs_at && !fired) begin
            crs_req <= 1'b1;
            fired = 1;
         end
         if (restart && crs && tick) held++;
         if (held == 3) crs_req <= 1'b0;
         @(negedge clk);
      end
      chk_bit({nm, " open"}, 1'b1, gap_ok);
      chk32(nm, e, 32'(n));
      crs_req <= 1'b0;
      $display("test %s done", nm);
   endtask

   task automatic give_verdict();
      $display("compared %0d mismatched %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // ****************************************
   // Clock, reset, watchdog and tests
   // ****************************************
   initial begin
      forever #2.5 clk = ~clk;
   end

   // The whole run needs under two thousand cycles; this ceiling cuts a hang.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         give_verdict();
      end
   end

   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk_bit("gap open after reset", 1'b1, gap_ok);
      reg_rd("b2b reset", `B2B_GAP_OFS, 4'hf, {25'h0, `B2B_GAP_RST});
      reg_rd("nb2b reset", `NB2B_GAP_OFS, 4'hf,
             {17'h0, `PART_ONE_RST, 1'b0, `PART_TWO_RST});
      reg_rd("tally reset", `FCS_TALLY_OFS, 4'hf, 32'h0);
      reg_rd("unmapped", 8'h40, 4'hf, 32'h0);
      $display("test reset done");
      frame(1'b1, 3'h0);
      frame(1'b1, 3'h0);
      frame(1'b1, 3'h3);
      frame(1'b0, 3'h0);
      gap_run("tx beside rx", 1'b1, 1'b1, -1, 1'b0, 21);
      reg_rd("tally kept", `FCS_TALLY_OFS, 4'hc, 32'h2);
      reg_rd("tally two", `FCS_TALLY_OFS, 4'hf, 32'h2);
      reg_rd("tally cleared", `FCS_TALLY_OFS, 4'hf, 32'h0);
      reg_wr(`FCS_TALLY_OFS, 32'hffff_ffff, 4'hf);
      reg_rd("tally upper zero", `FCS_TALLY_OFS, 4'hc, 32'hffff);
      frame(1'b1, 3'h0);
      reg_rd("tally wrap", `FCS_TALLY_OFS, 4'hf, 32'h0);
      reg_wr(`FCS_TALLY_OFS + 8'h08, 32'h5, 4'hf);
      reg_wr(`FCS_TALLY_OFS + 8'h04, 32'h4, 4'h3);
      reg_rd("tally aliases", `FCS_TALLY_OFS, 4'hf, 32'h1);
      $display("test tally done");
      reg_wr(`B2B_GAP_OFS + 8'h08, 32'h1, 4'hf);
      reg_wr(`B2B_GAP_OFS + 8'h04, 32'h2, 4'h3);
      reg_wr(`B2B_GAP_OFS + 8'h0c, 32'h7f, 4'hf);
      reg_rd("b2b aliases", `B2B_GAP_OFS, 4'hf, 32'h6e);
      reg_wr(`B2B_GAP_OFS, 32'h5, 4'h1);
      reg_rd("b2b byte ignored", `B2B_GAP_OFS, 4'hf, 32'h6e);
      reg_wr(`B2B_GAP_OFS, 32'h0, 4'hc);
      reg_rd("b2b upper half", `B2B_GAP_OFS, 4'hf, 32'h6e);
      reg_wr(`B2B_GAP_OFS, 32'hffff_ff15, 4'hf);
      reg_rd("b2b word", `B2B_GAP_OFS, 4'hf, 32'h15);
      $display("test gap registers done");
      gap_run("b2b full", 1'b1, 1'b1, -1, 1'b0, 24);
      reg_wr(`B2B_GAP_OFS, 32'h12, 4'h3);
      gap_run("b2b half", 1'b1, 1'b0, -1, 1'b0, 24);
      reg_wr(`B2B_GAP_OFS, 32'h2, 4'h3);
      gap_run("b2b small half", 1'b1, 1'b0, -1, 1'b0, 8);
      gap_run("b2b small full", 1'b1, 1'b1, -1, 1'b0, 5);
      gap_run("nb2b default", 1'b0, 1'b0, -1, 1'b0, 18);
      reg_wr(`NB2B_GAP_OFS, 32'h040a, 4'h3);
      reg_rd("nb2b written", `NB2B_GAP_OFS, 4'hf, 32'h040a);
      reg_wr(`NB2B_GAP_OFS, 32'h0101, 4'h2);
      reg_rd("nb2b byte ignored", `NB2B_GAP_OFS, 4'hf, 32'h040a);
      gap_run("defer to carrier", 1'b0, 1'b0, 2, 1'b1, 10);
      gap_run("carrier late", 1'b0, 1'b0, 6, 1'b0, 10);
      give_verdict();
   end
endmodule
